// File: rtl/adcc_pkg.sv
// Constants, tables and types shared by the converter control block.
package adcc_pkg;

  // Clock and time base.
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned OSC_HZ = 1_000_000;
  localparam int unsigned MOD_DIV = 4;
  localparam int unsigned MOD_HZ = OSC_HZ / MOD_DIV;
  localparam int unsigned OSC_DIV_CYC = CLK_HZ / OSC_HZ;
  localparam int unsigned RDY_PULSE_NS = 8000;
  localparam int unsigned RDY_PULSE_CYC =
    RDY_PULSE_NS / (1_000_000_000 / CLK_HZ);

  // Register indices on the plain port.
  localparam logic [2:0] REG_RESULT = 3'h0;
  localparam logic [2:0] REG_CONFIG = 3'h1;
  localparam logic [2:0] REG_LOWER = 3'h2;
  localparam logic [2:0] REG_UPPER = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;

  // Configuration field positions.
  localparam int CFG_START = 15;
  localparam int CFG_GAIN_LSB = 9;
  localparam int CFG_MODE = 8;
  localparam int CFG_RATE_LSB = 5;
  localparam int CFG_STYLE = 4;
  localparam int CFG_POL = 3;
  localparam int CFG_LATCH = 2;
  localparam int CFG_COUNT_LSB = 0;

  // Reset values, fixed gain code and general-call reset byte.
  localparam logic [2:0] GAIN_RST = 3'h2;
  localparam logic MODE_RST = 1'b1;
  localparam logic [2:0] RATE_RST = 3'h4;
  localparam logic [1:0] COUNT_OFF = 2'h3;
  localparam logic [15:0] LOWER_RST = 16'h8000;
  localparam logic [15:0] UPPER_RST = 16'h7fff;
  localparam logic [2:0] GAIN_FIXED = 3'h2;
  localparam logic [7:0] GCALL_RESET = 8'h06;

  // Full-scale half range in mV per gain code, and code step in pV.
  localparam logic [12:0] FSR_MV [8] =
    '{13'd6144, 13'd4096, 13'd2048, 13'd1024,
      13'd512, 13'd256, 13'd256, 13'd256};

  function automatic logic [31:0] lsb_pv(input logic [12:0] mv);
    lsb_pv = 32'(64'(mv) * 64'd2_000_000_000 / 64'd65536);
  endfunction

  // Modulator ticks per conversion, rounded up.
  function automatic logic [14:0] conv_ticks(input int unsigned sps);
    conv_ticks = 15'((MOD_HZ + sps - 1) / sps);
  endfunction

  localparam logic [14:0] CONV_TICKS [8] =
    '{conv_ticks(8), conv_ticks(16), conv_ticks(32), conv_ticks(64),
      conv_ticks(128), conv_ticks(250), conv_ticks(475),
      conv_ticks(860)};

  typedef enum logic {ST_IDLE, ST_CONV} adcc_phase_t;

endpackage

// File: rtl/adcc_control.sv
// Converter control: timing, comparator, alert/ready pin and registers.
// Contract
// RULE1: Modulator tick is oscillator divided by four.
// RULE2: Gain field selects one of six ranges.
// RULE3: Code step is full-scale span over 65536.
// RULE4: Without gain stage, range fixed at 2.048 V.
// RULE5: Rate field picks one of eight rates.
// RULE6: Conversion lasts one output period.
// RULE7: Style bit picks traditional or window comparison.
// RULE8: Traditional: set above upper, clear below lower.
// RULE9: Window: alert when above upper or below lower.
// RULE10: Latched alert clears on result read or response.
// RULE11: Polarity bit picks pin level, default low.
// RULE12: Count field needs 1/2/4 results; 11b disables.
// RULE13: Limit sign bits select conversion-ready pin use.
// RULE14: Continuous ready mode pulses about 8 us.
// RULE15: Single-shot ready mode drives pin at completion.
// RULE16: Cleared alert re-arms; conversions undisturbed.
// RULE17: Open-drain pin released when comparator disabled.
// RULE18: Asserted devices answer the alert response address; the code answers only while the latch bit is set.
// RULE19: Lowest address wins and clears; losers keep alert.
// RULE20: Window status bit: 1 upper, 0 lower.
// RULE21: Reset restores defaults and powers down.
// RULE22: General-call byte 06h resets like power-up.
// RULE23: Mode bit: 1 single-shot, 0 continuous.
// RULE24: Signed compare once per new result.
`timescale 1ns/1ps

module adcc_control #(
  parameter bit HAS_GAIN_STAGE = 1'b1,
  parameter int unsigned OSC_DIV = adcc_pkg::OSC_DIV_CYC
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port.
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Digital filter side.
  input wire logic [15:0] filt_data,
  output logic modulator_rate,
  output logic conv_start,
  output logic conv_done,
  output logic [2:0] gain_range_sel,
  output logic [12:0] fsr_mv,
  output logic [31:0] lsb_pv,
  // Serial framer events.
  input wire logic ara_won,
  input wire logic gcall_valid,
  input wire logic [7:0] gcall_byte,
  output logic ara_respond,
  output logic ara_status,
  // Alert/ready open-drain pin.
  output logic alert_ready_pin_o,
  output logic alert_ready_pin_oe
);

  typedef struct packed {
    adcc_pkg::adcc_phase_t phase;
    logic [15:0] osc_cnt;
    logic [1:0] mod_cnt;
    logic mod_tick;
    logic [14:0] conv_cnt;
    logic [2:0] cur_rate;
    logic start_pend;
    logic conv_start;
    logic conv_done;
    logic [2:0] gain;
    logic mode;
    logic [2:0] rate;
    logic style;
    logic pol;
    logic latch;
    logic [1:0] count_sel;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] result;
    logic [2:0] fault_cnt;
    logic alert;
    logic hi;
    logic [10:0] rdy_cnt;
    logic rdy_level;
    logic [15:0] rdata;
    logic [2:0] gain_eff;
    logic [12:0] fsr;
    logic [31:0] lsb;
    logic pin_oe;
    logic ara_resp;
  } adcc_st_t;

  // Power-up defaults; the general-call reset reuses them.
  function automatic adcc_st_t rst_val();
    adcc_st_t r;
    r = '0;
    r.phase = adcc_pkg::ST_IDLE;
    r.gain = adcc_pkg::GAIN_RST;
    r.mode = adcc_pkg::MODE_RST;
    r.rate = adcc_pkg::RATE_RST;
    r.count_sel = adcc_pkg::COUNT_OFF;
    r.upper = adcc_pkg::UPPER_RST;
    r.lower = adcc_pkg::LOWER_RST;
    r.gain_eff = adcc_pkg::GAIN_RST;
    r.fsr = adcc_pkg::FSR_MV[adcc_pkg::GAIN_RST];
    r.lsb = adcc_pkg::lsb_pv(adcc_pkg::FSR_MV[adcc_pkg::GAIN_RST]);
    return r;
  endfunction

  localparam logic [10:0] RDY_CYC = 11'(adcc_pkg::RDY_PULSE_CYC);

  adcc_st_t st_ff;
  adcc_st_t nxt_st;

  logic osc_tick;
  logic rdy_mode;
  logic cmp_on;
  logic out_hi;
  logic out_lo;
  logic out_any;
  logic reach;
  logic clr;
  logic pin_assert;
  logic [2:0] need;
  logic [2:0] cnt_new;
  logic [2:0] gsel;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    nxt_st.mod_tick = 1'b0;
    nxt_st.conv_start = 1'b0;
    nxt_st.conv_done = 1'b0;
    osc_tick = (st_ff.osc_cnt == 16'(OSC_DIV - 1));
    rdy_mode = st_ff.upper[15] & ~st_ff.lower[15]
      & (st_ff.count_sel != adcc_pkg::COUNT_OFF); // see RULE13
    cmp_on = (st_ff.count_sel != adcc_pkg::COUNT_OFF) & ~rdy_mode;
    need = 3'h1 << st_ff.count_sel; // see RULE12
    out_hi = $signed(filt_data) > $signed(st_ff.upper); // see RULE24
    out_lo = $signed(filt_data) < $signed(st_ff.lower); // see RULE24
    out_any = st_ff.style ? (out_hi | out_lo) : out_hi; // see RULE7
    cnt_new = 3'h0;
    reach = 1'b0;
    clr = (reg_rd & (reg_addr == adcc_pkg::REG_RESULT)) | ara_won;
    pin_assert = 1'b0;
    gsel = 3'h0;

    // Oscillator and modulator dividers.
    nxt_st.osc_cnt = osc_tick ? 16'h0 : st_ff.osc_cnt + 16'h1;
    if (osc_tick) begin
      nxt_st.mod_cnt = st_ff.mod_cnt + 2'h1;
      nxt_st.mod_tick = (st_ff.mod_cnt == 2'(adcc_pkg::MOD_DIV - 1)); // see RULE1
    end

    // Register writes.
    if (reg_wr) begin
      unique case (reg_addr)
        adcc_pkg::REG_CONFIG: begin
          nxt_st.gain = reg_wdata[adcc_pkg::CFG_GAIN_LSB +: 3]; // see RULE2
          nxt_st.mode = reg_wdata[adcc_pkg::CFG_MODE]; // see RULE23
          nxt_st.rate = reg_wdata[adcc_pkg::CFG_RATE_LSB +: 3]; // see RULE5
          nxt_st.style = reg_wdata[adcc_pkg::CFG_STYLE];
          nxt_st.pol = reg_wdata[adcc_pkg::CFG_POL]; // see RULE11
          nxt_st.latch = reg_wdata[adcc_pkg::CFG_LATCH];
          nxt_st.count_sel = reg_wdata[adcc_pkg::CFG_COUNT_LSB +: 2];
          // A start request during a conversion is dropped.
          if (reg_wdata[adcc_pkg::CFG_START] &&
              st_ff.phase == adcc_pkg::ST_IDLE) begin
            nxt_st.start_pend = 1'b1;
          end
        end
        adcc_pkg::REG_LOWER: nxt_st.lower = reg_wdata;
        adcc_pkg::REG_UPPER: nxt_st.upper = reg_wdata;
        default: ;
      endcase
    end

    // Conversion sequencing; the rate is held for the whole conversion.
    unique case (st_ff.phase)
      adcc_pkg::ST_IDLE: begin
        if (!st_ff.mode || st_ff.start_pend) begin // see RULE23
          nxt_st.phase = adcc_pkg::ST_CONV;
          nxt_st.conv_cnt = 15'h0;
          nxt_st.cur_rate = st_ff.rate;
          nxt_st.start_pend = 1'b0;
          nxt_st.conv_start = 1'b1;
          nxt_st.rdy_level = 1'b0;
        end
      end
      adcc_pkg::ST_CONV: begin
        if (st_ff.mod_tick) begin
          if (st_ff.conv_cnt ==
              adcc_pkg::CONV_TICKS[st_ff.cur_rate] - 15'h1) begin // see RULE6
            nxt_st.result = filt_data;
            nxt_st.conv_done = 1'b1;
            nxt_st.conv_cnt = 15'h0;
            if (!st_ff.mode) begin
              nxt_st.cur_rate = st_ff.rate;
              nxt_st.conv_start = 1'b1;
            end else begin
              nxt_st.phase = adcc_pkg::ST_IDLE;
            end
          end else begin
            nxt_st.conv_cnt = st_ff.conv_cnt + 15'h1;
          end
        end
      end
    endcase

    // Comparator. The clear goes first so a fresh trip overrides it.
    if (clr) begin
      nxt_st.alert = 1'b0; // see RULE10 RULE19
    end
    if (!cmp_on) begin
      nxt_st.fault_cnt = 3'h0;
      if (!rdy_mode) begin
        nxt_st.alert = 1'b0; // see RULE12
      end
    end else if (nxt_st.conv_done) begin
      cnt_new = out_any ? ((st_ff.fault_cnt == 3'h4) ? 3'h4
        : st_ff.fault_cnt + 3'h1) : 3'h0;
      nxt_st.fault_cnt = cnt_new;
      reach = cnt_new >= need; // see RULE12
      if (reach) begin
        nxt_st.alert = 1'b1; // see RULE16
        nxt_st.hi = out_hi; // see RULE20
      end else if (!st_ff.latch) begin
        if (st_ff.style) begin
          nxt_st.alert = 1'b0; // see RULE9
        end else if (out_lo) begin
          nxt_st.alert = 1'b0; // see RULE8
        end
      end
    end

    // Conversion-ready signalling.
    if (nxt_st.conv_done && rdy_mode && !st_ff.mode) begin
      nxt_st.rdy_cnt = RDY_CYC; // see RULE14
    end else if (st_ff.rdy_cnt != 11'h0) begin
      nxt_st.rdy_cnt = st_ff.rdy_cnt - 11'h1;
    end
    if (nxt_st.conv_done && st_ff.mode) begin
      nxt_st.rdy_level = 1'b1; // see RULE15
    end

    // Read data, valid in the cycle after the strobe.
    nxt_st.rdata = 16'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        adcc_pkg::REG_RESULT: nxt_st.rdata = st_ff.result;
        adcc_pkg::REG_CONFIG: nxt_st.rdata = {
          (st_ff.phase == adcc_pkg::ST_IDLE) & ~st_ff.start_pend,
          3'h0, st_ff.gain, st_ff.mode, st_ff.rate, st_ff.style,
          st_ff.pol, st_ff.latch, st_ff.count_sel};
        adcc_pkg::REG_LOWER: nxt_st.rdata = st_ff.lower;
        adcc_pkg::REG_UPPER: nxt_st.rdata = st_ff.upper;
        adcc_pkg::REG_STATUS: nxt_st.rdata = {11'h0, st_ff.fault_cnt,
          st_ff.hi, st_ff.alert};
        default: nxt_st.rdata = 16'h0;
      endcase
    end

    // General-call reset behaves as power-up.
    if (gcall_valid && gcall_byte == adcc_pkg::GCALL_RESET) begin
      nxt_st = rst_val(); // see RULE22
    end

    // Range outputs follow the final configuration.
    gsel = HAS_GAIN_STAGE ? nxt_st.gain : adcc_pkg::GAIN_FIXED; // see RULE4
    nxt_st.gain_eff = gsel;
    nxt_st.fsr = adcc_pkg::FSR_MV[gsel]; // see RULE2
    nxt_st.lsb = adcc_pkg::lsb_pv(adcc_pkg::FSR_MV[gsel]); // see RULE3

    // Pin drive from the final state. Output enable high drives the pin low.
    if (nxt_st.upper[15] && !nxt_st.lower[15] &&
        nxt_st.count_sel != adcc_pkg::COUNT_OFF) begin
      pin_assert = (nxt_st.rdy_cnt != 11'h0) | nxt_st.rdy_level;
    end else begin
      pin_assert = nxt_st.alert;
    end
    nxt_st.pin_oe = (nxt_st.count_sel != adcc_pkg::COUNT_OFF) &
      (pin_assert ^ nxt_st.pol); // see RULE11 RULE17
    nxt_st.ara_resp = nxt_st.alert & nxt_st.latch; // see RULE18
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= rst_val(); // see RULE21
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign modulator_rate = st_ff.mod_tick;
  assign conv_start = st_ff.conv_start;
  assign conv_done = st_ff.conv_done;
  assign gain_range_sel = st_ff.gain_eff;
  assign fsr_mv = st_ff.fsr;
  assign lsb_pv = st_ff.lsb;
  assign ara_respond = st_ff.ara_resp;
  assign ara_status = st_ff.hi;
  assign alert_ready_pin_o = 1'b0;
  assign alert_ready_pin_oe = st_ff.pin_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks. The tick gap counter is helper logic for them only.
  logic [15:0] tick_gap_ff;
  logic seen_tick_ff;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_gap_ff <= 16'h0;
      seen_tick_ff <= 1'b0;
    end else if (gcall_valid && gcall_byte == adcc_pkg::GCALL_RESET) begin
      // The dividers restart here, so the next gap is not a full one.
      seen_tick_ff <= 1'b0;
    end else if (st_ff.mod_tick) begin
      tick_gap_ff <= 16'h1;
      seen_tick_ff <= 1'b1;
    end else begin
      tick_gap_ff <= tick_gap_ff + 16'h1;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n || gcall_valid);

  a_mod_tick_gap: assert property ( // see RULE1
    st_ff.mod_tick && seen_tick_ff |->
      tick_gap_ff == 16'(adcc_pkg::MOD_DIV * OSC_DIV))
    else $error("modulator tick spacing wrong");
  a_step_span: assert property ( // see RULE3
    64'(st_ff.lsb) * 64'd65536 == 64'(st_ff.fsr) * 64'd2_000_000_000)
    else $error("code step does not match range");
  a_fixed_range: assert property ( // see RULE4
    !HAS_GAIN_STAGE |-> st_ff.gain_eff == adcc_pkg::GAIN_FIXED)
    else $error("fixed range not held");
  a_disabled_release: assert property ( // see RULE17
    st_ff.count_sel == adcc_pkg::COUNT_OFF |-> !alert_ready_pin_oe)
    else $error("pin driven while comparator disabled");
  a_window_trip: assert property ( // see RULE9
    st_ff.style && cmp_on && st_ff.count_sel == 2'h0 && !gcall_valid
      && !reg_wr && nxt_st.conv_done && (out_hi || out_lo)
      |=> st_ff.alert && $stable(st_ff.count_sel))
    else $error("window alert missed");
  a_trad_hold: assert property ( // see RULE8
    !st_ff.style && cmp_on && st_ff.alert && !clr && !reg_wr
      && nxt_st.conv_done && !out_lo |=> st_ff.alert)
    else $error("traditional alert dropped early");
  a_latch_keep: assert property ( // see RULE10
    st_ff.latch && cmp_on && st_ff.alert && !clr && !reg_wr
      |=> st_ff.alert)
    else $error("latched alert lost");
  a_read_clears: assert property ( // see RULE10
    cmp_on && st_ff.alert && clr && !nxt_st.conv_done |=> !st_ff.alert)
    else $error("alert not cleared");
  a_ready_pulse: assert property ( // see RULE14
    rdy_mode && !st_ff.mode && !reg_wr && nxt_st.conv_done
      |=> st_ff.rdy_cnt == RDY_CYC ##1 st_ff.rdy_cnt == RDY_CYC - 11'h1)
    else $error("ready pulse length wrong");
  // The mode must have stood at the edge that ended the conversion.
  a_conv_one_shot: assert property ( // see RULE23
    st_ff.mode && $stable(st_ff.mode) && st_ff.conv_done && !reg_wr
      |-> st_ff.phase == adcc_pkg::ST_IDLE && !st_ff.conv_start)
    else $error("single shot did not stop");

  c_window_alert: cover property (st_ff.style && $rose(st_ff.alert));
  c_ready_pulse: cover property (rdy_mode && st_ff.rdy_cnt == RDY_CYC);
  c_ara_clear: cover property (ara_won && st_ff.alert ##1 !st_ff.alert);

endmodule

// File: tb/adcc_far_model.sv
// Far-side model: result source for the filter and alert line pull-up.
`timescale 1ns/1ps

module adcc_far_model (
  // Filter side.
  input wire logic [15:0] sample_val,
  output logic [15:0] filt_data,
  // Alert line.
  input wire logic pin_o,
  input wire logic pin_oe,
  output logic pin_level
);
  assign filt_data = sample_val;
  // The line is pulled up, so a released pin reads high.
  assign pin_level = pin_oe ? pin_o : 1'b1;
endmodule

// File: tb/adc_compare_alert_control_test.sv
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); fails++; end end

module adc_compare_alert_control_test;
  logic sys_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0;
  logic ara_won = 0, gcall_valid = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0, smp = 16'h0;
  logic [15:0] reg_rdata, filt_data, rd_d;
  logic [7:0] gcall_byte = 8'h0;
  logic mod_tick, cst, cdn, ara_respond, ara_status, pin_o, pin_oe, pin;
  logic [2:0] gsel, gsel_fix;
  logic [12:0] fsr;
  logic [31:0] lsb;
  int fails = 0, checks_done = 0, n, k, gap;
  int m_up, m_lo, m_fc = 0, m_al = 0, m_st, m_sty, m_pol, m_lat, m_cnt;
  int fsr_tab [8] = '{6144, 4096, 2048, 1024, 512, 256, 256, 256};

  always #2.5 sys_clk = ~sys_clk;

  adcc_control #(.OSC_DIV(2)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .filt_data(filt_data),
    .modulator_rate(mod_tick), .conv_start(cst), .conv_done(cdn),
    .gain_range_sel(gsel), .fsr_mv(fsr), .lsb_pv(lsb), .ara_won(ara_won),
    .gcall_valid(gcall_valid), .gcall_byte(gcall_byte),
    .ara_respond(ara_respond), .ara_status(ara_status),
    .alert_ready_pin_o(pin_o), .alert_ready_pin_oe(pin_oe));

  adcc_far_model far (.sample_val(smp), .filt_data(filt_data),
    .pin_o(pin_o), .pin_oe(pin_oe), .pin_level(pin));

  // Variant without a gain stage; only its range code is compared.
  adcc_control #(.OSC_DIV(2), .HAS_GAIN_STAGE(1'b0)) uut_fixed (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
    .filt_data(filt_data), .modulator_rate(), .conv_start(), .conv_done(),
    .gain_range_sel(gsel_fix), .fsr_mv(), .lsb_pv(), .ara_won(ara_won),
    .gcall_valid(gcall_valid), .gcall_byte(gcall_byte), .ara_respond(),
    .ara_status(), .alert_ready_pin_o(), .alert_ready_pin_oe());

  //////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd_d = reg_rdata;
  endtask

  task automatic wait_done();
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      if (++n > 5000) begin
        fails++;
        end_sim();
      end
    end while (cdn !== 1'b1);
  endtask

  function automatic logic [15:0] cfg(int st, g, md, sty, pol, lat, cn);
    return 16'((st << 15) | (g << 9) | (md << 8) | (7 << 5) | (sty << 4) |
      (pol << 3) | (lat << 2) | cn);
  endfunction

  task automatic setup(int sty, pol, lat, cn, up, lo);
    m_sty = sty;
    m_pol = pol;
    m_lat = lat;
    m_cnt = cn;
    m_up = up;
    m_lo = lo;
    wr(2, 16'(lo));
    wr(3, 16'(up));
    wr(1, cfg(0, 2, 1, sty, pol, lat, cn));
  endtask

  task automatic chk_al();
    `CHK("pin", 1'(m_cnt == 3 || !(m_al ^ m_pol)), pin)
    rd(4);
    `CHK("alert", 1'(m_al), rd_d[0])
    `CHK("ara_respond", 1'(m_al && m_lat), ara_respond)
    if (m_al && m_lat) `CHK("ara_status", 1'(m_st), ara_status)
  endtask

  // Reference comparator: counts out-of-limit results and sets the alert.
  task automatic conv(int v);
    int need, out;
    need = (m_cnt == 0) ? 1 : (m_cnt == 1) ? 2 : 4;
    out = (v > m_up) || (m_sty && v < m_lo);
    @(posedge sys_clk);
    smp <= 16'(v);
    wr(1, cfg(1, 2, 1, m_sty, m_pol, m_lat, m_cnt));
    wait_done();
    `CHK("conv_len", 1'b1, 1'(n >= 2320 && n <= 2340))
    repeat (2) @(posedge sys_clk);
    #1;
    m_fc = out ? ((m_fc < 4) ? m_fc + 1 : 4) : 0;
    if (m_cnt == 3) begin
      m_fc = 0;
      m_al = 0;
    end else if (m_fc >= need) begin
      m_al = 1;
      m_st = v > m_up;
    end else if (!m_lat && (m_sty || v < m_lo))
      m_al = 0;
    chk_al();
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(87198));
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    `CHK("pin_rst", 1'b1, pin)
    `CHK("gain_rst", 3'h2, gsel)
    rd(1);
    `CHK("cfg_rst", 16'h8583, rd_d)
    rd(3);
    `CHK("upper_rst", 16'h7fff, rd_d)
    rd(7);
    `CHK("unmapped", 16'h0, rd_d)
    for (int g = 0; g < 8; g++) begin
      wr(1, cfg(0, g, 1, 0, 0, 0, 3));
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("fsr", 13'(fsr_tab[g]), fsr)
      `CHK("lsb", 32'(64'(fsr_tab[g]) * 1953125 / 64), lsb)
      `CHK("fix_gain", adcc_pkg::GAIN_FIXED, gsel_fix)
    end
    k = -1;
    gap = 0;
    repeat (20) begin
      @(posedge sys_clk);
      #1;
      if (k >= 0) k++;
      if (mod_tick === 1'b1) begin
        if (k > 0 && gap == 0) gap = k;
        k = 0;
      end
    end
    `CHK("tick_gap", 8, gap)
    // One single-shot conversion at the next-to-fastest rate.
    wr(1, cfg(1, 2, 1, 0, 0, 0, 3) & 16'hffdf);
    wait_done();
    k = int'(adcc_pkg::CONV_TICKS[6]) * 8;
    `CHK("rate6_len", 1'b1, 1'(n >= k - 7 && n <= k + 2))
    // Window, latched: trip, clear by response, trip low, clear by read.
    setup(1, 0, 1, 0, 100, -100);
    conv(200 + int'($urandom % 100));
    @(posedge sys_clk);
    ara_won <= 1'b1;
    @(posedge sys_clk);
    ara_won <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    m_al = 0;
    chk_al();
    conv(-300);
    rd(0);
    `CHK("result", 16'hfed4, rd_d)
    m_al = 0;
    chk_al();
    conv(0);
    // Traditional, two results needed, active high.
    setup(0, 1, 0, 1, 100, -100);
    conv(150);
    conv(150);
    conv(50);
    conv(-200);
    setup(1, 0, 0, 2, 100, -100);
    repeat (5) conv((($urandom % 2) ? 1 : -1) * int'(50 + $urandom % 200));
    setup(1, 0, 0, 3, 100, -100);
    conv(500);
    // Ready mode: single shot holds, continuous pulses.
    wr(2, 16'h0000);
    wr(3, 16'h8000);
    wr(1, cfg(1, 2, 1, 1, 0, 1, 0));
    wait_done();
    repeat (200) @(posedge sys_clk);
    #1;
    `CHK("rdy_single", 1'b0, pin)
    wr(1, cfg(0, 2, 0, 0, 0, 0, 0));
    wait_done();
    k = (pin === 1'b0);
    repeat (1700) begin
      @(posedge sys_clk);
      #1;
      if (pin === 1'b0) k++;
    end
    `CHK("rdy_len", int'(adcc_pkg::RDY_PULSE_CYC), k)
    @(posedge sys_clk);
    gcall_byte <= 8'h07;
    gcall_valid <= 1'b1;
    @(posedge sys_clk);
    gcall_valid <= 1'b0;
    rd(1);
    `CHK("cfg_keep", 1'b0, rd_d[8])
    @(posedge sys_clk);
    gcall_byte <= 8'h06;
    gcall_valid <= 1'b1;
    @(posedge sys_clk);
    gcall_valid <= 1'b0;
    rd(1);
    `CHK("cfg_gcall", 16'h8583, rd_d)
    end_sim();
  end
endmodule
